// file: hdl/sarc_defines.svh
// Register indices, field positions, reset values and timing figures of the converter control
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

`define SARC_IDX_CTRL   18'h0_fe58
`define SARC_IDX_MODE   18'h0_fe59
`define SARC_IDX_RESLO  18'h0_fe5a
`define SARC_IDX_RESHI  18'h0_fe5b
`define SARC_IDX_EVST   18'h0_fe5c
`define SARC_IDX_EVMK   18'h0_fe5d

`define SARC_CTRL_CHAN_HI  7
`define SARC_CTRL_CHAN_LO  4
`define SARC_CTRL_GO       2
`define SARC_CTRL_DONE     1
`define SARC_CTRL_IE       0
`define SARC_MODE_RES8     6
`define SARC_MODE_DIV_HI   1
`define SARC_MODE_DIV_LO   0
`define SARC_RESLO_DATA_HI 7
`define SARC_RESLO_DATA_LO 4
`define SARC_RESLO_DIV     0
`define SARC_EV_DONE       0
`define SARC_EV_ABORT      1

`define SARC_RST_BYTE   8'h00
`define SARC_RST_EV     2'h0

`define SARC_BASE12     16'h0034
`define SARC_BASE8      16'h0020
`define SARC_FIXED      16'h0002
`define SARC_THIRD      16'h0003

`define SARC_RESP_OKAY  2'h0
`define SARC_RESP_SLV   2'h2

`endif

// file: hdl/sarc_pkg.sv
// Types shared by the converter control modules
package sarc_pkg;

  typedef logic [3:0] sarc_chan_t;

  typedef enum logic [0:0] {
    SARC_IDLE,
    SARC_CONVERT
  } sarc_phase_t;

  typedef enum logic [2:0] {
    SARC_R_CTRL,
    SARC_R_MODE,
    SARC_R_RESLO,
    SARC_R_RESHI,
    SARC_R_EVST,
    SARC_R_EVMK,
    SARC_R_NONE
  } sarc_reg_t;

  typedef struct packed {
    sarc_phase_t phase;
    sarc_chan_t  chan;
    logic        ie;
    logic        done;
    logic        res8;
    logic [1:0]  div_lo;
    logic        div_hi;
    logic [7:0]  res_hi;
    logic [3:0]  res_lo;
    logic        first12;
    logic        conv_res8;
    logic [1:0]  ev_stat;
    logic [1:0]  ev_mask;
    logic        irq;
    logic        done_irq;
    logic        ref_en;
    sarc_chan_t  chan_out;
    logic        aw_have;
    logic [17:0] aw_idx;
    logic        w_have;
    logic [7:0]  w_byte;
    logic        w_en;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } sarc_state_t;

  typedef struct packed {
    logic [15:0] cnt;
  } sarc_tmr_state_t;

endpackage

// file: hdl/sarc_timer.sv
// Conversion time counter
`timescale 1ns/10ps
`include "sarc_defines.svh"

module sarc_timer (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic        stop,
  input  wire logic [15:0] cycles,
  output wire logic        expire
);
  import sarc_pkg::*;

  sarc_tmr_state_t t_q;
  sarc_tmr_state_t t_d;

  // Last cycle of the programmed time
  assign expire = (t_q.cnt == 16'h0001);

  always_comb begin
    t_d = t_q;
    if (load) begin
      t_d.cnt = cycles;
    end else if (stop) begin
      t_d.cnt = 16'h0000;
    end else if (t_q.cnt != 16'h0000) begin
      t_d.cnt = t_q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

endmodule

// file: hdl/sarc_ctrl.sv
// Converter control top: AXI4-Lite register file, sequencing and event interrupt
`timescale 1ns/10ps
`include "sarc_defines.svh"

module sarc_ctrl (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [19:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output wire logic             s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output wire logic             s_axi_wready,
  output wire logic [1:0]       s_axi_bresp,
  output wire logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [19:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output wire logic             s_axi_arready,
  output wire logic [31:0]      s_axi_rdata,
  output wire logic [1:0]       s_axi_rresp,
  output wire logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [11:0]      adc_code,
  output wire sarc_pkg::sarc_chan_t input_sel,
  output wire logic             ref_gen_en,
  output wire logic             conv_busy,
  output wire logic             done_irq,
  output wire logic             irq
);
  import sarc_pkg::*;

  logic        rst_n_meta_q;
  logic        rst_n_q;
  sarc_state_t s_q;
  sarc_state_t s_d;
  logic        wr_go;
  logic        wr_on;
  sarc_reg_t   wr_sel;
  sarc_reg_t   rd_sel;
  logic [7:0]  wb;
  logic        start_req;
  logic        abort_req;
  logic        finish;
  logic        tmr_expire;
  logic [15:0] tmr_cycles;
  logic        dbl_due;

  // Reset image of the whole state; doubling pending from reset
  localparam sarc_state_t SARC_RST_STATE = '{
    phase:     SARC_IDLE,
    chan:      4'h0,
    ie:        1'b0,
    done:      1'b0,
    res8:      1'b0,
    div_lo:    2'h0,
    div_hi:    1'b0,
    res_hi:    `SARC_RST_BYTE,
    res_lo:    4'h0,
    first12:   1'b1,
    conv_res8: 1'b0,
    ev_stat:   `SARC_RST_EV,
    ev_mask:   `SARC_RST_EV,
    irq:       1'b0,
    done_irq:  1'b0,
    ref_en:    1'b0,
    chan_out:  4'h0,
    aw_have:   1'b0,
    aw_idx:    18'h0_0000,
    w_have:    1'b0,
    w_byte:    8'h00,
    w_en:      1'b0,
    awready:   1'b0,
    wready:    1'b0,
    bvalid:    1'b0,
    bresp:     2'h0,
    arready:   1'b0,
    rvalid:    1'b0,
    rdata:     8'h00,
    rresp:     2'h0
  };

  function automatic sarc_reg_t reg_decode(input logic [17:0] idx);
    sarc_reg_t sel;
    case (idx)
      `SARC_IDX_CTRL: begin
        sel = SARC_R_CTRL;
      end
      `SARC_IDX_MODE: begin
        sel = SARC_R_MODE;
      end
      `SARC_IDX_RESLO: begin
        sel = SARC_R_RESLO;
      end
      `SARC_IDX_RESHI: begin
        sel = SARC_R_RESHI;
      end
      `SARC_IDX_EVST: begin
        sel = SARC_R_EVST;
      end
      `SARC_IDX_EVMK: begin
        sel = SARC_R_EVMK;
      end
      default: begin
        sel = SARC_R_NONE;
      end
    endcase
    return sel;
  endfunction

  // Ceiling of (base*N+2)/3, N = 2**dsel, with base*N+2 doubled before the division on request
  function automatic logic [15:0] conv_cycles(
    input logic       res8,
    input logic [2:0] dsel,
    input logic       dbl
  );
    logic [15:0] t;
    t = (res8 ? `SARC_BASE8 : `SARC_BASE12) << dsel;
    t = t + `SARC_FIXED;
    if (dbl) begin
      t = t << 1;
    end
    return (t + `SARC_FIXED) / `SARC_THIRD;
  endfunction

  // Control register as software reads it; reserved bit reads zero
  function automatic logic [7:0] ctrl_image(input sarc_state_t st);
    logic busy;
    busy = (st.phase == SARC_CONVERT);
    return {st.chan, 1'b0, busy, st.done, st.ie};
  endfunction

  // Mode image; reserved bits read zero
  function automatic logic [7:0] mode_image(input sarc_state_t st);
    return {1'b0, st.res8, 4'h0, st.div_lo};
  endfunction

  // Result-low image with the high divide bit in bit 0
  function automatic logic [7:0] reslo_image(input sarc_state_t st);
    return {st.res_lo, 3'h0, st.div_hi};
  endfunction

  // Reset release through two stages
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_n_meta_q <= 1'b0;
      rst_n_q      <= 1'b0;
    end else begin
      rst_n_meta_q <= 1'b1;
      rst_n_q      <= rst_n_meta_q;
    end
  end

  sarc_timer u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n_q),
    .load     (start_req),
    .stop     (abort_req),
    .cycles   (tmr_cycles),
    .expire   (tmr_expire)
  );

  // Doubling applies to a twelve-bit start only
  assign dbl_due    = s_q.first12 & ~s_q.res8;
  assign tmr_cycles = conv_cycles(s_q.res8,
                                  {s_q.div_hi, s_q.div_lo},
                                  dbl_due);

  always_comb begin
    s_d       = s_q;
    wr_go     = 1'b0;
    wr_on     = 1'b0;
    wr_sel    = SARC_R_NONE;
    rd_sel    = SARC_R_NONE;
    wb        = s_q.w_byte;
    start_req = 1'b0;
    abort_req = 1'b0;
    finish    = 1'b0;

    // Write address and data are taken independently
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx  = s_axi_awaddr[19:2];
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_byte = s_axi_wdata[7:0];
      s_d.w_en   = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      wr_go       = 1'b1;
      wr_sel      = reg_decode(s_q.aw_idx);
      wr_on       = wr_go && s_q.w_en;
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = (wr_sel == SARC_R_NONE) ? `SARC_RESP_SLV : `SARC_RESP_OKAY;
    end

    // Conversion end; results are written in this one cycle, res_lo only for a twelve-bit conversion
    finish = (s_q.phase == SARC_CONVERT) && tmr_expire;
    if (finish) begin
      s_d.phase = SARC_IDLE;
      if (s_q.conv_res8) begin
        s_d.res_hi = adc_code[11:4];
      end else begin
        s_d.res_hi  = adc_code[11:4];
        s_d.res_lo  = adc_code[3:0];
        s_d.first12 = 1'b0;
      end
    end

    // Register writes; reserved bits are not stored
    if (wr_on) begin
      case (wr_sel)
        SARC_R_CTRL: begin
          s_d.chan = wb[`SARC_CTRL_CHAN_HI:`SARC_CTRL_CHAN_LO];
          s_d.ie   = wb[`SARC_CTRL_IE];
          if (!wb[`SARC_CTRL_DONE]) begin
            s_d.done = 1'b0;
          end
          if (wb[`SARC_CTRL_GO] && s_q.phase == SARC_IDLE) begin
            start_req = 1'b1;
          end
          if (!wb[`SARC_CTRL_GO] && s_q.phase == SARC_CONVERT && !finish) begin
            abort_req = 1'b1;
          end
        end
        SARC_R_MODE: begin
          if (s_q.res8 && !wb[`SARC_MODE_RES8]) begin
            s_d.first12 = 1'b1;
          end
          s_d.res8   = wb[`SARC_MODE_RES8];
          s_d.div_lo = wb[`SARC_MODE_DIV_HI:`SARC_MODE_DIV_LO];
        end
        SARC_R_RESLO: begin
          s_d.res_lo = wb[`SARC_RESLO_DATA_HI:`SARC_RESLO_DATA_LO];
          s_d.div_hi = wb[`SARC_RESLO_DIV];
        end
        SARC_R_RESHI: begin
          s_d.res_hi = wb;
        end
        SARC_R_EVST: begin
          s_d.ev_stat = s_q.ev_stat & ~wb[1:0];
        end
        SARC_R_EVMK: begin
          s_d.ev_mask = wb[1:0];
        end
        default: begin
          s_d.ev_mask = s_d.ev_mask;
        end
      endcase
    end

    // Start latches resolution and channel for the whole conversion
    if (start_req) begin
      s_d.phase     = SARC_CONVERT;
      s_d.conv_res8 = s_q.res8;
      s_d.chan_out  = s_d.chan;
    end
    if (abort_req) begin
      s_d.phase = SARC_IDLE;
    end

    // Hardware sets win over software clears
    if (finish) begin
      s_d.done                  = 1'b1;
      s_d.ev_stat[`SARC_EV_DONE] = 1'b1;
    end
    if (abort_req) begin
      s_d.ev_stat[`SARC_EV_ABORT] = 1'b1;
    end

    s_d.ref_en   = (s_d.phase == SARC_CONVERT);
    s_d.done_irq = s_d.ie & s_d.done;
    s_d.irq      = |(s_d.ev_stat & s_d.ev_mask);

    // Read channel, one cycle to the answer
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid) begin
      rd_sel     = reg_decode(s_axi_araddr[19:2]);
      s_d.rvalid = 1'b1;
      s_d.rresp  = `SARC_RESP_OKAY;
      case (rd_sel)
        SARC_R_CTRL: begin
          s_d.rdata = ctrl_image(s_q);
        end
        SARC_R_MODE: begin
          s_d.rdata = mode_image(s_q);
        end
        SARC_R_RESLO: begin
          s_d.rdata = reslo_image(s_q);
        end
        SARC_R_RESHI: begin
          s_d.rdata = s_q.res_hi;
        end
        SARC_R_EVST: begin
          s_d.rdata = {6'h00, s_q.ev_stat};
        end
        SARC_R_EVMK: begin
          s_d.rdata = {6'h00, s_q.ev_mask};
        end
        default: begin
          s_d.rdata = `SARC_RST_BYTE;
          s_d.rresp = `SARC_RESP_SLV;
        end
      endcase
    end

    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= SARC_RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = {24'h00_0000, s_q.rdata};
  assign input_sel     = s_q.chan_out;
  assign ref_gen_en    = s_q.ref_en;
  assign conv_busy     = (s_q.phase == SARC_CONVERT);
  assign done_irq      = s_q.done_irq;
  assign irq           = s_q.irq;

endmodule

// file: tb/sarc_analog_model.sv
// Behavioural analog core facing the converter control
`timescale 1ns/10ps
module sarc_analog_model (
  input  wire logic                 core_clk,
  input  wire logic [11:0]          level,
  input  wire sarc_pkg::sarc_chan_t input_sel,
  input  wire logic                 ref_gen_en,
  output logic [11:0]               adc_code
);
  import sarc_pkg::*;
  logic [11:0] noise = 12'h0;
  always @(posedge core_clk) noise <= noise + 12'h9a7;
  // Code per channel only while the reference runs
  assign adc_code = ref_gen_en ? level ^ {3{input_sel}} : noise;
endmodule

// file: tb/sarc_ctrl_monitor.sv
// Concurrent checks on the converter control top ports
`timescale 1ns/10ps
module sarc_ctrl_monitor (
  input wire logic                 core_clk,
  input wire logic                 nrst,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire sarc_pkg::sarc_chan_t input_sel,
  input wire logic                 ref_gen_en,
  input wire logic                 conv_busy,
  input wire logic                 done_irq
);
  import sarc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  sequence conv_end;
    $fell(conv_busy);
  endsequence
  a_ref_tracks_busy: assert property (ref_gen_en == conv_busy)
    else $error("reference enable differs from busy");
  a_start_by_write: assert property ($rose(conv_busy) |-> $rose(s_axi_bvalid))
    else $error("conversion began without a write");
  a_end_after_time: assert property (conv_end |-> $past(conv_busy, 12) || $rose(s_axi_bvalid))
    else $error("conversion ended too early");
  a_done_kept: assert property ($fell(done_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("done request dropped without a write");
  a_irq_cause: assert property ($rose(done_irq) |->
      s_axi_bvalid || $past(s_axi_bvalid) || $past(conv_busy) || $past(conv_busy, 2))
    else $error("done request without completion or write");
  a_sel_held: assert property (conv_busy && $past(conv_busy) |-> $stable(input_sel))
    else $error("channel changed during conversion");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_read_release: assert property (rd_done |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
endmodule
bind sarc_ctrl sarc_ctrl_monitor u_mon (.*);

// file: tb/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module testbench;
  import sarc_pkg::*;
  localparam logic [19:0] CTRL = 20'h3_f960;
  localparam logic [19:0] MODE = 20'h3_f964;
  localparam logic [19:0] RLO  = 20'h3_f968;
  localparam logic [19:0] RHI  = 20'h3_f96c;
  localparam logic [19:0] EVS  = 20'h3_f970;
  localparam logic [19:0] EVM  = 20'h3_f974;
  logic        core_clk = 1'b0, nrst = 1'b0;
  logic [19:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, ce;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] adc_code, level = '0;
  sarc_chan_t  input_sel, sl;
  logic        ref_gen_en, conv_busy, done_irq, irq;
  int          errors = 0, checked = 0, seed = 61;
  logic [35:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] cq[$];
  logic [15:0] bn = '0;
  always #5 core_clk = ~core_clk;
  sarc_ctrl uut (.*);
  sarc_analog_model u_model (.*);
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge core_clk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    rq.push_back({r, 26'h0, d});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic late(input logic [1:0] v);
    @(posedge core_clk);
    chk({34'h0, done_irq, irq}, {34'h0, v});
  endtask
  task automatic rst;
    nrst <= 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, 2'b00, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({34'h0, s_axi_bresp}, {34'h0, bq.pop_front()});
    if (conv_busy) begin
      if (bn == 16'h0) sl <= input_sel;
      bn <= bn + 16'h1;
    end else if (bn != 16'h0) begin
      ce = cq.pop_front();
      chk({16'h0, sl, bn & {16{!ce[31]}}}, {16'h0, ce[19:0]});
      bn <= 16'h0;
    end
  end
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    logic       r8, p8, dbl;
    logic [2:0] d;
    logic [3:0] ch, lo;
    logic [11:0] code;
    logic [15:0] c;
    rst();
    for (int i = 0; i < 6; i++) rd(CTRL + 20'(4 * i), 8'h00);
    rd(20'h3_f978, 8'h00, 2'h2);
    wr(20'h3_f978, 8'h5a, 2'h2);
    wr(RHI, 8'h5a);
    rd(RHI, 8'h5a);
    $display("test reset_and_map done");
    lo = 4'h0;
    p8 = 1'b0;
    dbl = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r8 = (i == 3 || i == 5);
      d = 3'(i);
      ch = 4'(i % 7);
      if (p8 && !r8) dbl = 1'b1;
      p8 = r8;
      level <= 12'($random(seed));
      wr(MODE, {1'b0, r8, 4'h0, d[1:0]});
      rd(MODE, {1'b0, r8, 4'h0, d[1:0]});
      wr(RLO, {lo, 3'h0, d[2]});
      c = 16'((((r8 ? 32 : 52) * (1 << d) + 2) * ((!r8 && dbl) ? 2 : 1) + 2) / 3);
      cq.push_back({12'h0, ch, c});
      wr(CTRL, {ch, 4'h5});
      while (conv_busy) @(posedge core_clk);
      code = level ^ {3{ch}};
      if (!r8) begin
        lo = code[3:0];
        dbl = 1'b0;
      end
      rd(CTRL, {ch, 4'h3});
      rd(RHI, code[11:4]);
      rd(RLO, {lo, 3'h0, d[2]});
      late(2'b10);
      wr(CTRL, {ch, 4'h1});
      late(2'b00);
    end
    $display("test conversions done");
    wr(EVS, 8'h03);
    rd(EVS, 8'h00);
    wr(EVM, 8'h02);
    cq.push_back({1'b1, 11'h0, 4'h6, 16'h0});
    wr(CTRL, 8'h64);
    wr(CTRL, 8'h60);
    rd(CTRL, 8'h60);
    rd(RHI, code[11:4]);
    rd(EVS, 8'h02);
    late(2'b01);
    wr(EVM, 8'h01);
    late(2'b00);
    wr(EVM, 8'h03);
    late(2'b01);
    wr(EVS, 8'h02);
    late(2'b00);
    $display("test abort_and_events done");
    rst();
    rd(CTRL, 8'h00);
    rd(RHI, 8'h00);
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule
